// ---- inc/pt_cfg_params.svh ----
// Constants for the pass-thru region configuration block
`ifndef PT_CFG_PARAMS_SVH
`define PT_CFG_PARAMS_SVH

// Boot device byte addresses and last download index
`define NV_FEAT_ADDR    8'h45
`define NV_MASK_ADDR    8'h54
`define NV_LAST_IDX     5'h10

// Feature byte layout and value used until the download ends
`define FEAT_LAT_BIT    0
`define FEAT_DISC_BIT   1
`define FEAT_STALL_BIT  2
`define FEAT_DEFAULT    8'h01
`define FEAT_USED_MASK  8'h07

// Region base register fields
`define ATTR_IO_MASK    32'h0000_0003
`define ATTR_MEM_MASK   32'h0000_000F
`define WIDTH_MASK      32'hC000_0000
`define WIDTH_OFF       2'h0

// Target latency limits in PCI clocks and the data phase address step
`define LAT_FIRST       5'h10
`define LAT_NEXT        5'h08
`define ADDR_STEP       32'h0000_0004

// APB register byte offsets
`define OFF_BASE0       8'h00
`define OFF_BASE3       8'h0C
`define OFF_STATUS      8'h10
`define OFF_HOLD        8'h14

`endif

// ---- inc/pt_cfg_pkg.sv ----
// Types shared by the pass-thru region configuration design
package pt_cfg_pkg;

  typedef enum logic [1:0] {
    BOOT_IDLE,
    BOOT_REQ,
    BOOT_DONE
  } boot_state_e;

  typedef enum logic [0:0] {
    TERM_IDLE,
    TERM_DATA
  } term_state_e;

endpackage

// ---- rtl/nv_boot_loader.sv ----
// Boot download of region masks and feature byte from the serial store
`timescale 1ns/1ps
`include "pt_cfg_params.svh"

module nv_boot_loader (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              present_i,
  output logic                   req_o,
  output logic [7:0]             addr_o,
  input  wire logic [7:0]        data_i,
  input  wire logic              valid_i,
  output logic [3:0][31:0]       masks_o,
  output logic [7:0]             feat_o,
  output logic                   done_o
);

  pt_cfg_pkg::boot_state_e state_reg;
  logic [4:0]              idx_reg;
  logic [3:0]              byte_idx;
  logic [7:0]              feat_raw_reg;

  assign byte_idx = 4'(idx_reg - 5'h01);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg    <= pt_cfg_pkg::BOOT_IDLE;
      idx_reg      <= 5'h00;
      req_o        <= 1'b0;
      addr_o       <= 8'h00;
      masks_o      <= '0;
      feat_raw_reg <= 8'h00;
      feat_o       <= `FEAT_DEFAULT;
      done_o       <= 1'b0;
    end else begin
      case (state_reg)
        pt_cfg_pkg::BOOT_IDLE: begin
          // Strap sampled after reset release; no store keeps masks zero
          if (present_i) begin
            state_reg <= pt_cfg_pkg::BOOT_REQ;
            req_o     <= 1'b1;
            addr_o    <= `NV_FEAT_ADDR;
          end else begin
            state_reg <= pt_cfg_pkg::BOOT_DONE;
            done_o    <= 1'b1;
          end
        end
        pt_cfg_pkg::BOOT_REQ: begin
          if (valid_i) begin
            if (idx_reg == 5'h00) begin
              feat_raw_reg <= data_i;
            end else begin
              masks_o[byte_idx[3:2]][8*byte_idx[1:0] +: 8] <= data_i; // see RQ1
            end
            if (idx_reg == `NV_LAST_IDX) begin
              state_reg <= pt_cfg_pkg::BOOT_DONE;
              req_o     <= 1'b0;
              done_o    <= 1'b1;
              feat_o    <= feat_raw_reg & `FEAT_USED_MASK; // see RQ7 RQ19
            end else begin
              idx_reg <= idx_reg + 5'h01;
              addr_o  <= `NV_MASK_ADDR + {4'h0, idx_reg[3:0]}; // see RQ1
            end
          end
        end
        default: begin
          state_reg <= pt_cfg_pkg::BOOT_DONE;
        end
      endcase
    end
  end

endmodule

// ---- rtl/pci_passthru_region_config.sv ----
// Pass-thru region base registers, boot masks and target termination
//
// Behaviour
// RQ1: After reset, load four region masks from store bytes 54h..63h.
// RQ2: All-ones write then read returns zeros where the mask has zeros.
// RQ3: Host assigns each region a base aligned to its size.
// RQ4: Mask BFFFF002h gives 4 KB, below 1 MB, 16-bit, non-prefetch memory.
// RQ5: Mask FFFFFF81h gives a 128-byte, 32-bit I/O region.
// RQ6: Mask with top two bits zero leaves the region disabled.
// RQ7: Feature byte at 45h: latency, discard, stall mode bits.
// RQ8: Latency on: data within 16 clocks first, 8 later, else disconnect.
// RQ9: Latency off: never disconnect for slow add-on; insert wait states.
// RQ10: Discard off: keep read data, retry other masters meanwhile.
// RQ11: Discard on: flush held data when next read address differs.
// RQ12: Data held after a no-data retry until that master returns.
// RQ13: Stall off: disconnect at once on full write queue.
// RQ14: Stall on: wait for room, disconnect 8 clocks after last phase.
// RQ15: Region register reads return the assigned base address.
// RQ16: Mask bits 31:30 give add-on width; 00 disables the region.
// RQ17: Bits 31:30 read back as copies of bit 29.
// RQ18: Without boot store all region registers stay zero.
// RQ19: Reserved feature bits ignored; features apply after download.
// RQ20: Host writes change only bits the mask leaves writable.
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "pt_cfg_params.svh"

module pci_passthru_region_config #(
  parameter int REGIONS = 4
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // APB register port
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Boot store byte reader
  input  wire logic        NV_PRESENT_I,
  output logic             NV_REQ_O,
  output logic      [7:0]  NV_ADDR_O,
  input  wire logic [7:0]  NV_DATA_I,
  input  wire logic        NV_VALID_I,
  // PCI target sequencing
  input  wire logic        TXN_START_I,
  input  wire logic        TXN_WRITE_I,
  input  wire logic [31:0] TXN_ADDR_I,
  input  wire logic [3:0]  TXN_MASTER_I,
  input  wire logic        TXN_LAST_I,
  input  wire logic        ADDON_READY_I,
  input  wire logic        WFIFO_FULL_I,
  output logic             TRDY_O,
  output logic             STOP_O,
  output logic             QUEUE_FLUSH_O,
  output logic             READ_HELD_O,
  output logic      [7:0]  REGION_WIDTH_O,
  output logic             BOOT_DONE_O
);

  logic [3:0][31:0]        masks;
  logic [7:0]              feat;
  logic                    boot_done;
  logic                    boot_seen_reg;
  logic [REGIONS-1:0][31:0] base_reg;
  logic [REGIONS-1:0][31:0] base_rd;
  logic                    latency_en;
  logic                    discard_en;
  logic                    stall_en;

  nv_boot_loader u_loader (
    .clk_i     (CLK_I),
    .rst_i     (RST_I),
    .present_i (NV_PRESENT_I),
    .req_o     (NV_REQ_O),
    .addr_o    (NV_ADDR_O),
    .data_i    (NV_DATA_I),
    .valid_i   (NV_VALID_I),
    .masks_o   (masks),
    .feat_o    (feat),
    .done_o    (boot_done)
  );

  // Loader holds the default byte until done, reserved bits already dropped
  assign latency_en = feat[`FEAT_LAT_BIT];   // see RQ19
  assign discard_en = feat[`FEAT_DISC_BIT];
  assign stall_en   = feat[`FEAT_STALL_BIT];

  // APB slave: no wait cycle; read data is registered during the setup cycle
  logic       apb_setup;
  logic       apb_commit;
  logic       addr_ok;
  logic [31:0] rd_value;

  assign apb_setup  = PSEL_I && !PENABLE_I;
  assign apb_commit = PSEL_I && PENABLE_I && PREADY_O;
  assign addr_ok    = (PADDR_I[1:0] == 2'h0) && (PADDR_I <= `OFF_HOLD);

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      boot_seen_reg <= 1'b0;
      BOOT_DONE_O   <= 1'b0;
    end else begin
      boot_seen_reg <= boot_done;
      BOOT_DONE_O   <= boot_done;
    end
  end

  genvar g;
  generate
    for (g = 0; g < REGIONS; g++) begin : g_region
      logic [31:0] attr;
      logic [31:0] writable;
      logic        enabled;
      logic        wr_hit;

      assign attr     = masks[g][0] ? `ATTR_IO_MASK : `ATTR_MEM_MASK;
      assign writable = masks[g] & ~attr & ~`WIDTH_MASK; // see RQ20
      assign enabled  = masks[g][31:30] != `WIDTH_OFF;   // see RQ6 RQ16
      assign wr_hit   = apb_commit && PWRITE_I &&
                        (PADDR_I == `OFF_BASE0 + 8'(4 * g));

      always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
          base_reg[g]          <= 32'h0000_0000; // see RQ18
          REGION_WIDTH_O[2*g +: 2] <= `WIDTH_OFF;
        end else if (boot_done && !boot_seen_reg) begin
          base_reg[g] <= enabled ? (masks[g] & attr) : 32'h0000_0000;
          REGION_WIDTH_O[2*g +: 2] <= masks[g][31:30]; // see RQ16
        end else if (wr_hit && enabled) begin
          // Attribute bits stay as the mask sets them; see RQ2 RQ4 RQ5 RQ20
          base_reg[g] <= (PWDATA_I & writable) | (masks[g] & attr);
        end
      end

      // Width bits are private; they mirror bit 29 on reads, see RQ15 RQ17
      assign base_rd[g] = enabled ? {{2{base_reg[g][29]}}, base_reg[g][29:0]}
                                  : 32'h0000_0000;
    end
  endgenerate

  // Termination engine state
  pt_cfg_pkg::term_state_e state_reg;
  logic [4:0]  cnt_reg;
  logic        first_reg;
  logic        xfer_reg;
  logic        cur_write_reg;
  logic [31:0] cur_addr_reg;
  logic [3:0]  cur_master_reg;
  logic        hold_reg;
  logic        hold_retry_reg;
  logic [3:0]  holder_reg;
  logic [31:0] hold_addr_reg;

  logic        in_data;
  logic        ready_now;
  logic        block_other;
  logic        flush_now;
  logic        full_stop;
  logic        lat_stop;
  logic        stop_now;
  logic [4:0]  limit;

  assign in_data   = state_reg == pt_cfg_pkg::TERM_DATA;
  assign ready_now = cur_write_reg ? !WFIFO_FULL_I : ADDON_READY_I;
  assign limit     = first_reg ? `LAT_FIRST : `LAT_NEXT;
  // Other masters are kept out while held data waits with discard off or after a no-data retry; see RQ10 RQ12
  assign block_other = hold_reg && (TXN_MASTER_I != holder_reg) &&
                       (!discard_en || hold_retry_reg);
  // See RQ11
  assign flush_now = TXN_START_I && !in_data && hold_reg && discard_en &&
                     !hold_retry_reg && !TXN_WRITE_I &&
                     (TXN_ADDR_I != hold_addr_reg);
  assign full_stop = in_data && cur_write_reg && WFIFO_FULL_I &&
                     !stall_en;                                // see RQ13
  // Latency timer only disconnects when enabled, or for a stalled write; see RQ9
  assign lat_stop  = in_data && !ready_now &&
                     (cnt_reg + 5'h01 >= limit) &&
                     (latency_en || (cur_write_reg && stall_en)); // see RQ8 RQ14
  assign stop_now  = full_stop || lat_stop;

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_reg      <= pt_cfg_pkg::TERM_IDLE;
      cnt_reg        <= 5'h00;
      first_reg      <= 1'b1;
      xfer_reg       <= 1'b0;
      cur_write_reg  <= 1'b0;
      cur_addr_reg   <= 32'h0000_0000;
      cur_master_reg <= 4'h0;
      TRDY_O         <= 1'b0;
      STOP_O         <= 1'b0;
    end else begin
      TRDY_O <= 1'b0;
      STOP_O <= 1'b0;
      case (state_reg)
        pt_cfg_pkg::TERM_IDLE: begin
          if (TXN_START_I && block_other) begin
            STOP_O <= 1'b1; // see RQ10
          end else if (TXN_START_I) begin
            state_reg      <= pt_cfg_pkg::TERM_DATA;
            cnt_reg        <= 5'h00;
            first_reg      <= 1'b1;
            xfer_reg       <= 1'b0;
            cur_write_reg  <= TXN_WRITE_I;
            cur_addr_reg   <= TXN_ADDR_I;
            cur_master_reg <= TXN_MASTER_I;
          end
        end
        default: begin
          if (ready_now) begin
            TRDY_O       <= 1'b1;
            cnt_reg      <= 5'h00;
            first_reg    <= 1'b0;
            xfer_reg     <= 1'b1;
            cur_addr_reg <= cur_addr_reg + `ADDR_STEP;
            if (TXN_LAST_I) begin
              state_reg <= pt_cfg_pkg::TERM_IDLE;
            end
          end else if (stop_now) begin
            STOP_O    <= 1'b1;
            state_reg <= pt_cfg_pkg::TERM_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 5'h01; // Wait state, see RQ9 RQ14
          end
        end
      endcase
    end
  end

  // Read data holding across a disconnect
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      hold_reg       <= 1'b0;
      hold_retry_reg <= 1'b0;
      holder_reg     <= 4'h0;
      hold_addr_reg  <= 32'h0000_0000;
      QUEUE_FLUSH_O  <= 1'b0;
      READ_HELD_O    <= 1'b0;
    end else begin
      QUEUE_FLUSH_O <= flush_now;
      if (stop_now && !cur_write_reg) begin
        hold_reg       <= 1'b1;                 // see RQ10
        hold_retry_reg <= !xfer_reg;            // see RQ12
        holder_reg     <= cur_master_reg;
        hold_addr_reg  <= cur_addr_reg;
        READ_HELD_O    <= 1'b1;
      end else if (flush_now || (in_data && ready_now && TXN_LAST_I &&
                   !cur_write_reg && cur_master_reg == holder_reg)) begin
        hold_reg    <= 1'b0;
        READ_HELD_O <= 1'b0;
      end
    end
  end

  // Register read mux
  always_comb begin
    rd_value = 32'h0000_0000;
    if (PADDR_I <= `OFF_BASE3) begin
      rd_value = base_rd[PADDR_I[3:2]]; // see RQ15
    end else if (PADDR_I == `OFF_STATUS) begin
      rd_value = {21'h000000, stall_en, discard_en, latency_en,
                  7'h00, boot_done};
    end else if (PADDR_I == `OFF_HOLD) begin
      rd_value = {26'h0000000, holder_reg, hold_retry_reg, hold_reg};
    end
  end

  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O  <= apb_setup;
      PSLVERR_O <= apb_setup && !addr_ok;
      if (apb_setup && !PWRITE_I) begin
        PRDATA_O <= addr_ok ? rd_value : 32'h0000_0000;
      end
    end
  end

  // Checks
  a_retry_other: assert property (@(posedge CLK_I) disable iff (RST_I)
    (!in_data && TXN_START_I && hold_reg && !discard_en &&
     TXN_MASTER_I != holder_reg) |=> (STOP_O && !TRDY_O))
    else $error("other master not retried while data held"); // see RQ10
  a_first_latency: assert property (@(posedge CLK_I) disable iff (RST_I)
    (in_data && first_reg && cnt_reg == 5'h0F && !ready_now && latency_en)
    |=> STOP_O)
    else $error("no disconnect at first phase latency"); // see RQ8
  a_next_latency: assert property (@(posedge CLK_I) disable iff (RST_I)
    (in_data && !first_reg && cnt_reg == 5'h07 && !ready_now && latency_en)
    |=> STOP_O)
    else $error("no disconnect at later phase latency"); // see RQ8
  a_no_lat_stop: assert property (@(posedge CLK_I) disable iff (RST_I)
    (in_data && !latency_en && !cur_write_reg) |=> !STOP_O)
    else $error("disconnect with latency disabled"); // see RQ9
  a_full_disconnect: assert property (@(posedge CLK_I) disable iff (RST_I)
    (in_data && cur_write_reg && WFIFO_FULL_I && !stall_en)
    |=> (STOP_O && state_reg == pt_cfg_pkg::TERM_IDLE))
    else $error("full write queue not disconnected"); // see RQ13
  a_full_stall: assert property (@(posedge CLK_I) disable iff (RST_I)
    (in_data && cur_write_reg && WFIFO_FULL_I && stall_en && !first_reg &&
     cnt_reg < 5'h07) |=> (!STOP_O && !TRDY_O))
    else $error("stalled write ended early"); // see RQ14
  a_flush_diff: assert property (@(posedge CLK_I) disable iff (RST_I)
    (!in_data && TXN_START_I && hold_reg && !hold_retry_reg && discard_en &&
     !TXN_WRITE_I && TXN_ADDR_I != hold_addr_reg) |=> QUEUE_FLUSH_O)
    else $error("held data not flushed"); // see RQ11
  a_retry_keep: assert property (@(posedge CLK_I) disable iff (RST_I)
    (hold_reg && hold_retry_reg) |=> !QUEUE_FLUSH_O)
    else $error("retry data flushed"); // see RQ12
  a_feat_default: assert property (@(posedge CLK_I) disable iff (RST_I)
    !boot_done |-> (latency_en && !discard_en && !stall_en))
    else $error("features applied before download"); // see RQ19
  a_width_mirror: assert property (@(posedge CLK_I) disable iff (RST_I)
    (apb_setup && !PWRITE_I && PADDR_I <= `OFF_BASE3) |=>
    (PRDATA_O[31] == PRDATA_O[29] && PRDATA_O[30] == PRDATA_O[29]))
    else $error("width bits not mirrored"); // see RQ17
  a_disabled_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
    (apb_setup && !PWRITE_I && PADDR_I <= `OFF_BASE3 &&
     REGION_WIDTH_O[2*PADDR_I[3:2] +: 2] == `WIDTH_OFF && BOOT_DONE_O)
    |=> PRDATA_O == 32'h0000_0000)
    else $error("disabled region reads nonzero"); // see RQ6
  a_mask_attr: assert property (@(posedge CLK_I) disable iff (RST_I)
    (boot_done && !boot_seen_reg && masks[0] == 32'hBFFFF002) |=>
    (REGION_WIDTH_O[1:0] == 2'h2 && base_reg[0][3:0] == 4'h2))
    else $error("memory mask attributes wrong"); // see RQ4

endmodule

// ---- tb/nv_store_model.sv ----
// Serial boot store stand-in that answers byte reads of masks and features
`timescale 1ns/1ps

module nv_store_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       req_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] feat_i,
  output logic      [7:0] data_o,
  output logic            valid_o
);
  logic [1:0] gap;
  logic       slow;

  function automatic logic [7:0] byte_at(input logic [7:0] a);
    logic [31:0] m;
    logic [7:0]  k;
    k = a - 8'h54;
    case (k[3:2])
      2'h0: m = 32'hBFFF_F002;
      2'h1: m = 32'h3000_0000;
      2'h2: m = 32'hFFFF_FF81;
      default: m = 32'h0000_0000;
    endcase
    if (a == 8'h45) return feat_i;
    if (a < 8'h54 || a > 8'h63) return 8'hFF;
    return m[8*k[1:0] +: 8];
  endfunction

  // Prompt and slow answers alternate; an idle data line never holds a byte
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      data_o  <= 8'hA5;
      gap     <= 2'h0;
      slow    <= 1'b0;
    end else if (valid_o) begin
      valid_o <= 1'b0;
      data_o  <= ~data_o;
      gap     <= slow ? 2'h3 : 2'h1;
    end else if (req_i && gap == 2'h0) begin
      valid_o <= 1'b1;
      data_o  <= byte_at(addr_i);
      slow    <= ~slow;
    end else begin
      gap     <= (gap == 2'h0) ? 2'h0 : gap - 2'h1;
      data_o  <= ~data_o;
    end
  end
endmodule

// ---- tb/tb_pci_passthru_region_config.sv ----
// Self-checking bench for the pass-thru region configuration block
`timescale 1ns/1ps

`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  error_cnt++; $display("mismatch %s exp %h got %h", nm, ex, got); end end

module tb_pci_passthru_region_config;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d, ex; logic er;} row_s;
  logic CLK_I = 0, RST_I = 1, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0;
  logic [7:0] PADDR_I = 0, feat = 8'hF9, REGION_WIDTH_O, NV_ADDR_O, NV_DATA_I;
  logic [31:0] PWDATA_I = 0, PRDATA_O, TXN_ADDR_I = 0, rd;
  logic PREADY_O, PSLVERR_O, NV_PRESENT_I = 0, NV_REQ_O, NV_VALID_I, er;
  logic TXN_START_I = 0, TXN_WRITE_I = 0, TXN_LAST_I = 0, ADDON_READY_I = 0;
  logic [3:0] TXN_MASTER_I = 0;
  logic WFIFO_FULL_I = 0, TRDY_O, STOP_O, QUEUE_FLUSH_O, READ_HELD_O;
  logic BOOT_DONE_O, t, s, fl;
  int error_cnt = 0, tests_run = 0, n;
  logic [7:0] seen[$];
  row_s rows[17] = '{
    '{1, 8'h00, 32'hFFFF_FFFF, 0, 0}, '{0, 8'h00, 0, 32'hFFFF_F002, 0},
    '{1, 8'h08, 32'hFFFF_FFFF, 0, 0}, '{0, 8'h08, 0, 32'hFFFF_FF81, 0},
    '{1, 8'h0C, 32'hFFFF_FFFF, 0, 0}, '{0, 8'h0C, 0, 32'h0000_0000, 0},
    // Host bases sit on multiples of the region size
    '{1, 8'h00, 32'h000A_0000, 0, 0}, '{0, 8'h00, 0, 32'h000A_0002, 0},
    '{1, 8'h00, 32'h2000_0000, 0, 0}, '{0, 8'h00, 0, 32'hE000_0002, 0},
    '{1, 8'h08, 32'h0000_E000, 0, 0}, '{0, 8'h08, 0, 32'h0000_E001, 0},
    '{0, 8'h10, 0, 32'h0000_0101, 0}, '{1, 8'h10, 32'hFFFF_FFFF, 0, 0},
    '{0, 8'h10, 0, 32'h0000_0101, 0}, '{0, 8'h18, 0, 32'h0000_0000, 1},
    '{1, 8'h18, 32'h1234_5678, 0, 1}};

  always #2 CLK_I = ~CLK_I;

  pci_passthru_region_config #(.REGIONS(4)) uut (.*);

  nv_store_model store (.clk_i(CLK_I), .rst_i(RST_I), .req_i(NV_REQ_O),
    .addr_i(NV_ADDR_O), .feat_i(feat), .data_o(NV_DATA_I),
    .valid_o(NV_VALID_I));

  always @(posedge CLK_I) if (NV_REQ_O && NV_VALID_I) seen.push_back(NV_ADDR_O);

  task automatic report_and_stop();
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK_I);
    PSEL_I <= 1; PWRITE_I <= w; PADDR_I <= a; PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1;
    do begin
      @(posedge CLK_I);
      k++;
    end while (PREADY_O !== 1'b1 && k < 20);
    rd = PRDATA_O;
    er = PSLVERR_O;
    PSEL_I <= 0;
    PENABLE_I <= 0;
  endtask

  task automatic boot(input logic p, input logic [7:0] f);
    int k;
    @(posedge CLK_I);
    RST_I <= 1; NV_PRESENT_I <= p; feat <= f;
    repeat (5) @(posedge CLK_I);
    RST_I <= 0;
    seen.delete();
    for (k = 0; k < 300 && BOOT_DONE_O !== 1'b1 && p; k++) @(posedge CLK_I);
    repeat (3) @(posedge CLK_I);
  endtask

  // Raise a start; ev drops it so a one-cycle retry answer is not missed
  task automatic go(input logic w, input logic [31:0] a, input logic [3:0] m);
    @(posedge CLK_I);
    TXN_START_I <= 1; TXN_WRITE_I <= w; TXN_ADDR_I <= a; TXN_MASTER_I <= m;
  endtask

  task automatic ev(input int rdy_at);
    n = 0; t = 0; s = 0; fl = 0;
    while (!t && !s && n < 100) begin
      @(posedge CLK_I);
      n++;
      TXN_START_I <= 0;
      ADDON_READY_I <= (n == rdy_at);
      #1;
      t = TRDY_O; s = STOP_O; fl |= QUEUE_FLUSH_O;
    end
  endtask

  initial begin
    #200000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    boot(0, 8'hF9);
    repeat (40) @(posedge CLK_I);
    `CHK("width none", 8'h00, REGION_WIDTH_O)
    apb(1, 8'h00, 32'hFFFF_FFFF);
    apb(0, 8'h00, 0);
    `CHK("base none", 32'h0, rd)
    boot(1, 8'hF9);
    `CHK("addr count", 17, seen.size())
    `CHK("first addr", 8'h45, seen[0])
    `CHK("last addr", 8'h63, seen[16])
    `CHK("width", 8'h32, REGION_WIDTH_O)
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      `CHK("slverr", rows[i].er, er)
      if (!rows[i].wr) `CHK("rdata", rows[i].ex, rd)
    end
    // Latency on: silent first phase, then a later phase after one word
    go(0, 32'h000A_0000, 4'h1);
    ev(0);
    `CHK("first stop", 17, n)
    `CHK("first trdy", 1'b0, t)
    `CHK("retry held", 1'b1, READ_HELD_O)
    go(0, 32'h000A_0000, 4'h2);
    ev(0);
    `CHK("other retried", 1, n)
    TXN_LAST_I <= 0;
    go(0, 32'h000A_0000, 4'h1);
    ev(3);
    `CHK("trdy at", 4, n)
    ev(0);
    `CHK("later stop", 8, n)
    go(1, 32'h000A_0000, 4'h1);
    WFIFO_FULL_I <= 1;
    ev(0);
    `CHK("full stop", 1'b1, s)
    `CHK("full stop at", 2, n)
    WFIFO_FULL_I <= 0;
    // Discard on: a different address from another master flushes
    boot(1, 8'h03);
    apb(0, 8'h10, 0);
    `CHK("status b", 32'h0000_0301, rd)
    go(0, 32'h000A_0000, 4'h1);
    ev(2);
    ev(0);
    go(0, 32'h000A_0040, 4'h2);
    ev(2);
    `CHK("flush", 1'b1, fl)
    // Latency off, stall on, reserved bits set
    boot(1, 8'hFC);
    apb(0, 8'h10, 0);
    `CHK("status c", 32'h0000_0401, rd)
    TXN_LAST_I <= 1;
    go(0, 32'h000A_0000, 4'h3);
    ev(60);
    `CHK("wait states", 61, n)
    `CHK("slow trdy", 1'b1, t)
    go(1, 32'h000A_0000, 4'h3);
    WFIFO_FULL_I <= 1;
    ev(0);
    `CHK("stall stop", 17, n)
    WFIFO_FULL_I <= 0;
    report_and_stop();
  end
endmodule
